// [pm_regs_defines.svh]
// register addresses, field positions and reset values for the power hint register bank
`ifndef PM_REGS_DEFINES_SVH
`define PM_REGS_DEFINES_SVH
`define ADDR_THERM_EXCURSION   12'h19C
`define ADDR_BIAS_HINT         12'h1B0
`define ADDR_PROD_PERF_COUNT   12'h64E
`define ADDR_PM_FEATURE_EN     12'h770
`define ADDR_PERF_RANGE_CAP    12'h771
`define ADDR_PKG_PERF_REQ      12'h772
`define ADDR_PERF_CHG_INT      12'h773
`define ADDR_PROC_PERF_REQ     12'h774
`define ADDR_EXT_OVERRIDE      12'h775
`define ADDR_PERF_CHG_STATUS   12'h777
`define BIAS_HINT_W            4
`define BIAS_HINT_RESET        4'h0
`define BIAS_HINT_MAX_PERF     4'h0
`define BIAS_HINT_BALANCED     4'h7
`define BIAS_HINT_MAX_SAVE     4'hF
`define AUTONOMY_BIT           0
`define AUTONOMY_RESET         1'b0
`define ECX_BIAS_SUPPORT_BIT   3
`define EAX_BASELINE_BIT       7
`define EAX_NOTIFY_BIT         8
`define EAX_WINDOW_BIT         9
`define EAX_EPP_BIT            10
`define EAX_PKG_CTRL_BIT       11
`define EPP_LSB                24
`define EPP_MSB                31
`define PERF_FIELD_W           8
`define REQ_MIN_LSB            0
`define REQ_MAX_LSB            8
`define REQ_DES_LSB            16
`define REQ_WIN_LSB            32
`define REQ_WIN_W              10
`define REQ_PKG_CTRL_BIT       42
`define REQ_WIN_VALID          59
`define REQ_EPP_VALID          60
`define REQ_DES_VALID          61
`define REQ_MAX_VALID          62
`define REQ_MIN_VALID          63
`define REQ_MIN_MASK           64'hFF
`define REQ_MAX_MASK           64'hFF00
`define REQ_DES_MASK           64'hFF_0000
`define REQ_EPP_MASK           64'hFF00_0000
`define REQ_WIN_MASK           64'h3FF_0000_0000
`define REQ_RESET              64'h0000_0000_8000_0000
`define PKG_RESET              64'h0000_0000_8000_0000
`define INT_RESET              64'h0
`endif

// [pm_regs_pkg.sv]
// types shared by the power hint register bank
package pm_regs_pkg;
    // one register access request from a logical processor
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  lp;
        logic [11:0] addr;
        logic [63:0] wdata;
    } reg_req_t;
    // answer to a register access
    typedef struct packed {
        logic        valid;
        logic        fault;
        logic [63:0] rdata;
    } reg_rsp_t;
    // identification leaf 6 result bits that this block owns
    typedef struct packed {
        logic [31:0] eax;
        logic [31:0] ecx;
    } ident_leaf6_t;
endpackage

// [lp_reg_store.sv]
// small per-logical-processor storage with registered read data
`timescale 1ns/10ps
module lp_reg_store #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_sync_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data,
    output logic      [WIDTH*DEPTH-1:0]   all_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    // one entry per logical processor, all reset to the same default
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= RESET_VAL;
            end
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    // read data come out of a register
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_data <= RESET_VAL;
        end else begin
            rd_data <= mem_r[rd_idx];
        end
    end

    // flat view for the resolution logic
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_data[i*WIDTH +: WIDTH] = mem_r[i];
        end
    end
endmodule // lp_reg_store

// [perf_hint_and_autonomy_enable_bit_regs.sv]
// model-specific register bank: bias hints, autonomy enable and performance request registers
`timescale 1ns/10ps
`include "pm_regs_defines.svh"
module perf_hint_and_autonomy_enable_bit_regs #(
    parameter int         NUM_LP         = 4,
    parameter logic       FEAT_BASELINE  = 1'b1,
    parameter logic       FEAT_NOTIFY    = 1'b1,
    parameter logic       FEAT_WINDOW    = 1'b1,
    parameter logic       FEAT_EPP       = 1'b1,
    parameter logic       FEAT_PKG_CTRL  = 1'b1,
    parameter logic       FEAT_BIAS_HINT = 1'b1
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire pm_regs_pkg::reg_req_t          req,
    output pm_regs_pkg::reg_rsp_t               rsp,
    output pm_regs_pkg::ident_leaf6_t           ident_leaf6,
    input  wire logic [63:0]                    perf_range_capabilities,
    input  wire logic [63:0]                    perf_change_status,
    input  wire logic [63:0]                    external_override_request_info,
    input  wire logic [63:0]                    thermal_status_excursion_reasons,
    input  wire logic [63:0]                    productive_perf_count,
    input  wire logic                           legacy_perf_req_valid,
    input  wire logic [$clog2(NUM_LP)-1:0]      legacy_perf_req_lp,
    input  wire logic [15:0]                    legacy_perf_req_target,
    output logic                                hw_managed_perf_states,
    output logic      [`BIAS_HINT_W-1:0]        resolved_bias_hint,
    output logic      [NUM_LP*8-1:0]            lp_min_perf,
    output logic      [NUM_LP*8-1:0]            lp_max_perf,
    output logic      [NUM_LP*8-1:0]            lp_desired_perf,
    output logic      [NUM_LP*8-1:0]            lp_energy_pref,
    output logic      [NUM_LP*10-1:0]           lp_activity_window,
    output logic                                legacy_perf_valid,
    output logic      [$clog2(NUM_LP)-1:0]      legacy_perf_lp,
    output logic      [15:0]                    legacy_perf_target
);
    localparam int LPW = $clog2(NUM_LP);

    // reset release through two flops; assertion still takes effect at once
    logic rst_meta_r;
    logic rst_sync_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // address decode of the whole bank
    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    logic autonomy_enable_bit_r;
    logic access_any;
    logic hit_bias;
    logic hit_enable;
    logic hit_cap;
    logic hit_pkg;
    logic hit_int;
    logic hit_req;
    logic hit_ext;
    logic hit_stat;
    logic hit_therm;
    logic hit_pperf;
    logic allowed;

    assign access_any = req.rd | req.wr;
    assign hit_bias   = FEAT_BIAS_HINT && is_addr(req.addr, `ADDR_BIAS_HINT);
    assign hit_enable = FEAT_BASELINE && is_addr(req.addr, `ADDR_PM_FEATURE_EN);
    assign hit_cap    = FEAT_BASELINE && is_addr(req.addr, `ADDR_PERF_RANGE_CAP);
    assign hit_pkg    = FEAT_PKG_CTRL && is_addr(req.addr, `ADDR_PKG_PERF_REQ);
    assign hit_int    = FEAT_NOTIFY && is_addr(req.addr, `ADDR_PERF_CHG_INT);
    assign hit_req    = FEAT_BASELINE && is_addr(req.addr, `ADDR_PROC_PERF_REQ);
    assign hit_ext    = FEAT_BASELINE && is_addr(req.addr, `ADDR_EXT_OVERRIDE);
    assign hit_stat   = FEAT_BASELINE && is_addr(req.addr, `ADDR_PERF_CHG_STATUS);
    assign hit_therm  = is_addr(req.addr, `ADDR_THERM_EXCURSION);
    assign hit_pperf  = is_addr(req.addr, `ADDR_PROD_PERF_COUNT);

    // gating: capability, request, package, override and status registers wait for enable; interrupt and bias hint only need presence
    always_comb begin
        allowed = 1'b0;
        if (hit_bias || hit_enable || hit_therm || hit_pperf || hit_int) begin
            allowed = 1'b1;
        end else if (hit_cap || hit_pkg || hit_req || hit_ext || hit_stat) begin
            allowed = autonomy_enable_bit_r;
        end
    end

    logic wr_ok;
    assign wr_ok = req.wr && allowed;

    // package-wide enable: set once, never cleared except by reset
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            autonomy_enable_bit_r <= `AUTONOMY_RESET;
        end else if (wr_ok && hit_enable && !autonomy_enable_bit_r) begin
            autonomy_enable_bit_r <= req.wdata[`AUTONOMY_BIT];
        end
    end
    assign hw_managed_perf_states = autonomy_enable_bit_r;

    // per logical processor bias hints
    logic [`BIAS_HINT_W-1:0]        bias_rd;
    logic [`BIAS_HINT_W*NUM_LP-1:0] bias_all;
    lp_reg_store #(
        .WIDTH     (`BIAS_HINT_W),
        .DEPTH     (NUM_LP),
        .RESET_VAL (`BIAS_HINT_RESET)
    ) u_bias_store (
        .ref_clk    (ref_clk),
        .rst_sync_n (rst_sync_n),
        .wr_en      (wr_ok && hit_bias),
        .wr_idx     (req.lp[LPW-1:0]),
        .wr_data    (req.wdata[`BIAS_HINT_W-1:0]),
        .rd_idx     (req.lp[LPW-1:0]),
        .rd_data    (bias_rd),
        .all_data   (bias_all)
    );

    // per logical processor performance requests
    logic [63:0]        preq_rd;
    logic [64*NUM_LP-1:0] preq_all;
    lp_reg_store #(
        .WIDTH     (64),
        .DEPTH     (NUM_LP),
        .RESET_VAL (`REQ_RESET)
    ) u_req_store (
        .ref_clk    (ref_clk),
        .rst_sync_n (rst_sync_n),
        .wr_en      (wr_ok && hit_req),
        .wr_idx     (req.lp[LPW-1:0]),
        .wr_data    (req.wdata),
        .rd_idx     (req.lp[LPW-1:0]),
        .rd_data    (preq_rd),
        .all_data   (preq_all)
    );

    // package request and interrupt control, one copy each per package
    logic [63:0] pkg_req_r;
    logic [63:0] int_ctrl_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pkg_req_r <= `PKG_RESET;
        end else if (wr_ok && hit_pkg) begin
            pkg_req_r <= req.wdata;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_ctrl_r <= `INT_RESET;
        end else if (wr_ok && hit_int) begin
            int_ctrl_r <= req.wdata;
        end
    end

    // the lowest hint across processors wins, since it favours performance
    function automatic logic [`BIAS_HINT_W-1:0] min_hint(input logic [`BIAS_HINT_W*NUM_LP-1:0] v);
        logic [`BIAS_HINT_W-1:0] m;
        m = `BIAS_HINT_MAX_SAVE;
        for (int i = 0; i < NUM_LP; i++) begin
            if (v[i*`BIAS_HINT_W +: `BIAS_HINT_W] < m) begin
                m = v[i*`BIAS_HINT_W +: `BIAS_HINT_W];
            end
        end
        min_hint = m;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            resolved_bias_hint <= `BIAS_HINT_RESET;
        end else begin
            resolved_bias_hint <= min_hint(bias_all);
        end
    end

    // bias hint scaled into the 8-bit preference range, 0 stays top performance
    function automatic logic [7:0] hint_to_pref(input logic [`BIAS_HINT_W-1:0] h);
        hint_to_pref = {h, h};
    endfunction

    // a package field replaces the own field only while its valid bit is clear
    function automatic logic [63:0] take_pkg(input logic [63:0] own,
                                             input logic [63:0] pkg,
                                             input logic [63:0] mask,
                                             input logic        keep_own);
        take_pkg = keep_own ? own : ((own & ~mask) | (pkg & mask));
    endfunction

    // effective request per processor; valid bits never masked, so later merges still see them
    logic [63:0] eff_req [NUM_LP];
    always_comb begin
        for (int i = 0; i < NUM_LP; i++) begin
            eff_req[i] = preq_all[i*64 +: 64];
            if (FEAT_PKG_CTRL && eff_req[i][`REQ_PKG_CTRL_BIT]) begin
                eff_req[i] = take_pkg(eff_req[i], pkg_req_r, `REQ_MIN_MASK, eff_req[i][`REQ_MIN_VALID]);
                eff_req[i] = take_pkg(eff_req[i], pkg_req_r, `REQ_MAX_MASK, eff_req[i][`REQ_MAX_VALID]);
                eff_req[i] = take_pkg(eff_req[i], pkg_req_r, `REQ_DES_MASK, eff_req[i][`REQ_DES_VALID]);
                eff_req[i] = take_pkg(eff_req[i], pkg_req_r, `REQ_EPP_MASK, eff_req[i][`REQ_EPP_VALID]);
                eff_req[i] = take_pkg(eff_req[i], pkg_req_r, `REQ_WIN_MASK, eff_req[i][`REQ_WIN_VALID]);
            end
        end
    end

    // limits and target handed to the autonomous selector; levels are abstract integers
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lp_min_perf     <= '0;
            lp_max_perf     <= '0;
            lp_desired_perf <= '0;
        end else begin
            for (int i = 0; i < NUM_LP; i++) begin
                lp_min_perf[i*8 +: 8]     <= eff_req[i][`REQ_MIN_LSB +: `PERF_FIELD_W];
                lp_max_perf[i*8 +: 8]     <= eff_req[i][`REQ_MAX_LSB +: `PERF_FIELD_W];
                lp_desired_perf[i*8 +: 8] <= eff_req[i][`REQ_DES_LSB +: `PERF_FIELD_W];
            end
        end
    end

    // efficiency preference; without its own field the bias hint stands in
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lp_energy_pref <= '0;
        end else begin
            for (int i = 0; i < NUM_LP; i++) begin
                lp_energy_pref[i*8 +: 8] <= FEAT_EPP ? eff_req[i][`EPP_MSB:`EPP_LSB]
                                            : hint_to_pref(bias_all[i*`BIAS_HINT_W +: `BIAS_HINT_W]);
            end
        end
    end

    // history window; zero leaves the window choice to the selector
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lp_activity_window <= '0;
        end else begin
            for (int i = 0; i < NUM_LP; i++) begin
                lp_activity_window[i*10 +: 10] <= FEAT_WINDOW ? eff_req[i][`REQ_WIN_LSB +: `REQ_WIN_W]
                                                  : 10'h000;
            end
        end
    end

    // legacy control passes only while the autonomous mode is off
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            legacy_perf_valid  <= 1'b0;
            legacy_perf_lp     <= '0;
            legacy_perf_target <= 16'h0000;
        end else begin
            legacy_perf_valid  <= legacy_perf_req_valid && !autonomy_enable_bit_r;
            legacy_perf_lp     <= legacy_perf_req_lp;
            legacy_perf_target <= legacy_perf_req_target;
        end
    end

    // feature flags for identification leaf 6
    always_comb begin
        ident_leaf6 = '0;
        ident_leaf6.eax[`EAX_BASELINE_BIT] = FEAT_BASELINE;
        ident_leaf6.eax[`EAX_NOTIFY_BIT]   = FEAT_NOTIFY;
        ident_leaf6.eax[`EAX_WINDOW_BIT]   = FEAT_WINDOW;
        ident_leaf6.eax[`EAX_EPP_BIT]      = FEAT_EPP;
        ident_leaf6.eax[`EAX_PKG_CTRL_BIT] = FEAT_PKG_CTRL;
        ident_leaf6.ecx[`ECX_BIAS_SUPPORT_BIT] = FEAT_BIAS_HINT;
    end

    // read answer one cycle after the request, matching the store's registered data
    logic        rd_d_r;
    logic        wr_d_r;
    logic        fault_d_r;
    logic [63:0] rd_mux_r;
    logic [3:0]  rd_sel_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_d_r    <= 1'b0;
            wr_d_r    <= 1'b0;
            fault_d_r <= 1'b0;
            rd_sel_r  <= 4'h0;
            rd_mux_r  <= 64'h0;
        end else begin
            rd_d_r    <= req.rd;
            wr_d_r    <= req.wr;
            fault_d_r <= access_any && !allowed;
            rd_sel_r  <= {hit_bias, hit_req, 2'b00};
            unique case (1'b1)
                hit_enable: rd_mux_r <= {63'h0, autonomy_enable_bit_r};
                hit_cap:    rd_mux_r <= perf_range_capabilities;
                hit_pkg:    rd_mux_r <= pkg_req_r;
                hit_int:    rd_mux_r <= int_ctrl_r;
                hit_ext:    rd_mux_r <= external_override_request_info;
                hit_stat:   rd_mux_r <= perf_change_status;
                hit_therm:  rd_mux_r <= thermal_status_excursion_reasons;
                hit_pperf:  rd_mux_r <= productive_perf_count;
                default:    rd_mux_r <= 64'h0;
            endcase
        end
    end

    // final answer; bias reads pad upper bits with zero
    always_comb begin
        rsp.valid = rd_d_r | wr_d_r;
        rsp.fault = fault_d_r;
        if (!rd_d_r || fault_d_r) begin
            rsp.rdata = 64'h0;
        end else if (rd_sel_r[3]) begin
            rsp.rdata = {60'h0, bias_rd};
        end else if (rd_sel_r[2]) begin
            rsp.rdata = preq_rd;
        end else begin
            rsp.rdata = rd_mux_r;
        end
    end
endmodule // perf_hint_and_autonomy_enable_bit_regs

// [pm_regs_chk.sv]
// concurrent checks on the ports of the power hint register bank
`timescale 1ns/10ps
`include "pm_regs_defines.svh"
module pm_regs_chk #(
    parameter int NUM_LP = 4
) (
    input wire logic                      ref_clk,
    input wire logic                      rst_n,
    input wire pm_regs_pkg::reg_req_t     req,
    input wire pm_regs_pkg::reg_rsp_t     rsp,
    input wire pm_regs_pkg::ident_leaf6_t ident_leaf6,
    input wire logic                      legacy_perf_req_valid,
    input wire logic [15:0]               legacy_perf_req_target,
    input wire logic                      hw_managed_perf_states,
    input wire logic                      legacy_perf_valid,
    input wire logic [15:0]               legacy_perf_target
);
    // one clock domain, reset pin disables everything
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_answer_next: assert property ((req.rd || req.wr) |=> rsp.valid)
        else $error("no answer one cycle after a request");
    a_no_stray_answer: assert property (!(req.rd || req.wr) |=> !rsp.valid)
        else $error("answer without a request");
    a_enable_sticky: assert property (hw_managed_perf_states |=> hw_managed_perf_states)
        else $error("autonomy enable cleared without reset");
    a_enable_sets: assert property (req.wr && req.addr == `ADDR_PM_FEATURE_EN && req.wdata[0]
        |=> hw_managed_perf_states)
        else $error("enable write did not take effect");
    a_legacy_ignored: assert property ($past(hw_managed_perf_states) |-> !legacy_perf_valid)
        else $error("legacy request passed while autonomous");
    a_legacy_passed: assert property (legacy_perf_req_valid && !hw_managed_perf_states ##1 !hw_managed_perf_states
        |-> legacy_perf_valid && legacy_perf_target == $past(legacy_perf_req_target))
        else $error("legacy request lost while not autonomous");
    a_bias_upper_zero: assert property (req.rd && req.addr == `ADDR_BIAS_HINT
        |=> rsp.rdata[63:4] == 60'h0)
        else $error("bias hint upper bits not zero");
    a_gated_refused: assert property (req.rd && req.addr == `ADDR_PROC_PERF_REQ && !hw_managed_perf_states
        |=> rsp.fault)
        else $error("request register reachable before enable");
    a_fault_no_data: assert property (rsp.fault |-> rsp.rdata == 64'h0)
        else $error("refused access returned data");
    a_flags_shown: assert property (ident_leaf6.eax[11:7] == 5'h1F && ident_leaf6.ecx[3])
        else $error("feature flags missing");

    // main scenarios reached
    c_enable_write: cover property (req.wr && req.addr == `ADDR_PM_FEATURE_EN && !hw_managed_perf_states);
    c_refused: cover property (rsp.valid && rsp.fault);
    c_legacy_blocked: cover property (legacy_perf_req_valid && hw_managed_perf_states);
endmodule // pm_regs_chk

bind perf_hint_and_autonomy_enable_bit_regs pm_regs_chk #(.NUM_LP(NUM_LP)) chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rsp(rsp), .ident_leaf6(ident_leaf6),
    .legacy_perf_req_valid(legacy_perf_req_valid), .legacy_perf_req_target(legacy_perf_req_target),
    .hw_managed_perf_states(hw_managed_perf_states), .legacy_perf_valid(legacy_perf_valid),
    .legacy_perf_target(legacy_perf_target));

// [tb_top.sv]
// self-checking testbench for the power hint register bank
`timescale 1ns/10ps
`include "pm_regs_defines.svh"
module tb_top;
    logic                      ref_clk;
    logic                      rst_n = 1'h0;
    pm_regs_pkg::reg_req_t     req = '0;
    pm_regs_pkg::reg_rsp_t     rsp, got;
    pm_regs_pkg::ident_leaf6_t ident_leaf6;
    logic [63:0]               caps = 64'h0000_0000_0A1E_2832, stat = 64'h5, ovr = 64'h1234;
    logic [63:0]               therm = 64'h8000, pperf = 64'h0001_2345;
    logic                      leg_v = 1'h0, hw_on, leg_v_o;
    logic [1:0]                leg_lp = 2'h0, leg_lp_o;
    logic [15:0]               leg_tgt = 16'h0, leg_tgt_o;
    logic [3:0]                res_hint;
    logic [31:0]               min_p, max_p, des_p, epp_p;
    logic [39:0]               win_p;
    int                        error_cnt = 0;
    int                        cmp_count = 0;

    perf_hint_and_autonomy_enable_bit_regs perf_hint_and_autonomy_enable_bit_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rsp(rsp), .ident_leaf6(ident_leaf6),
        .perf_range_capabilities(caps), .perf_change_status(stat), .external_override_request_info(ovr),
        .thermal_status_excursion_reasons(therm), .productive_perf_count(pperf),
        .legacy_perf_req_valid(leg_v), .legacy_perf_req_lp(leg_lp), .legacy_perf_req_target(leg_tgt),
        .hw_managed_perf_states(hw_on), .resolved_bias_hint(res_hint), .lp_min_perf(min_p),
        .lp_max_perf(max_p), .lp_desired_perf(des_p), .lp_energy_pref(epp_p), .lp_activity_window(win_p),
        .legacy_perf_valid(leg_v_o), .legacy_perf_lp(leg_lp_o), .legacy_perf_target(leg_tgt_o));

    // 20 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check64(input logic [63:0] g, input logic [63:0] e, input string what);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask

    task automatic check_rsp(input logic exp_fault);
        cmp_count++;
        if (got.valid !== 1'h1 || got.fault !== exp_fault) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: answer valid %b fault %b", $time, got.valid, got.fault);
        end
    endtask

    // one request held for exactly one taking edge, answer sampled once settled
    task automatic access(input logic w, input logic [1:0] lp, input logic [11:0] a, input logic [63:0] d);
        @(posedge ref_clk);
        req <= '{rd: !w, wr: w, lp: lp, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
        #1 got = rsp;
    endtask

    task automatic rd(input logic [1:0] lp, input logic [11:0] a, input logic [63:0] e, input logic f);
        access(1'h0, lp, a, 64'h0);
        check_rsp(f);
        check64(got.rdata, e, "rdata");
    endtask

    task automatic wr(input logic [1:0] lp, input logic [11:0] a, input logic [63:0] d);
        access(1'h1, lp, a, d);
        check_rsp(1'h0);
    endtask

    // first request only at the third edge after release
    task automatic do_reset;
        @(posedge ref_clk);
        rst_n <= 1'h0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic t_reset_state;
        check64({63'h0, hw_on}, 64'h0, "enable");
        rd(2'h0, `ADDR_BIAS_HINT, 64'h0, 1'h0);
        rd(2'h0, `ADDR_PM_FEATURE_EN, 64'h0, 1'h0);
        rd(2'h1, `ADDR_PROC_PERF_REQ, 64'h0, 1'h1);
        rd(2'h2, `ADDR_PKG_PERF_REQ, 64'h0, 1'h1);
        rd(2'h0, `ADDR_PERF_CHG_INT, `INT_RESET, 1'h0);
        rd(2'h3, `ADDR_PROD_PERF_COUNT, pperf, 1'h0);
        rd(2'h0, `ADDR_THERM_EXCURSION, therm, 1'h0);
        check64({32'h0, ident_leaf6.ecx}, 64'h8, "ecx");
        check64({32'h0, ident_leaf6.eax} & 64'hF80, 64'hF80, "eax");
    endtask

    // junk in the upper bits must not stick; the lowest hint wins
    task automatic t_bias_hints;
        logic [3:0] hv [4] = '{4'h9, 4'hF, 4'h7, 4'hC};
        for (int i = 0; i < 4; i++) begin
            wr(2'(i), `ADDR_BIAS_HINT, {60'hFFF_FFFF_FFFF_FFFF, hv[i]});
        end
        for (int i = 0; i < 4; i++) begin
            rd(2'(i), `ADDR_BIAS_HINT, {60'h0, hv[i]}, 1'h0);
        end
        check64({60'h0, res_hint}, 64'h7, "resolved");
        wr(2'h3, `ADDR_BIAS_HINT, 64'h0);
        @(posedge ref_clk);
        #1 check64({60'h0, res_hint}, 64'h0, "resolved");
    endtask

    task automatic t_legacy(input logic exp_v);
        @(posedge ref_clk);
        leg_v <= 1'h1;
        leg_lp <= 2'h3;
        leg_tgt <= 16'h1A2B;
        @(posedge ref_clk);
        leg_v <= 1'h0;
        #1 check64({63'h0, leg_v_o}, {63'h0, exp_v}, "legacy valid");
        if (exp_v) begin
            check64({46'h0, leg_lp_o, leg_tgt_o}, {46'h0, 2'h3, 16'h1A2B}, "legacy");
        end
    endtask

    task automatic t_enable;
        wr(2'h1, `ADDR_PM_FEATURE_EN, 64'hFFFF_FFFF_FFFF_FFFE);
        rd(2'h2, `ADDR_PM_FEATURE_EN, 64'h0, 1'h0);
        wr(2'h1, `ADDR_PM_FEATURE_EN, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(2'h3, `ADDR_PM_FEATURE_EN, 64'h1, 1'h0);
        wr(2'h0, `ADDR_PM_FEATURE_EN, 64'h0);
        check64({63'h0, hw_on}, 64'h1, "enable");
        t_legacy(1'h0);
        rd(2'h1, `ADDR_PROC_PERF_REQ, `REQ_RESET, 1'h0);
        rd(2'h0, `ADDR_PKG_PERF_REQ, `PKG_RESET, 1'h0);
        rd(2'h0, `ADDR_PERF_RANGE_CAP, caps, 1'h0);
        rd(2'h2, `ADDR_EXT_OVERRIDE, ovr, 1'h0);
        rd(2'h0, `ADDR_PERF_CHG_STATUS, stat, 1'h0);
        rd(2'h0, 12'h776, 64'h0, 1'h1);
        wr(2'h1, `ADDR_PROC_PERF_REQ, 64'h0000_0000_3344_5566);
        @(posedge ref_clk);
        #1 check64({min_p, max_p}, 64'h0000_6600_0000_5500, "limits");
        check64({des_p, epp_p}, 64'h0000_4400_8080_3380, "targets");
        wr(2'h0, `ADDR_PKG_PERF_REQ, 64'h0000_0155_7788_99AA);
        wr(2'h2, `ADDR_PROC_PERF_REQ, 64'h1000_0400_1122_3344);
        @(posedge ref_clk);
        #1 check64({min_p, max_p}, 64'h00AA_6600_0099_5500, "pkg limits");
        check64({des_p, epp_p}, 64'h0088_4400_8011_3380, "pkg targets");
        check64({24'h0, win_p}, 64'h0000_0000_1550_0000, "window");
    endtask

    // main sequence
    initial begin
        do_reset();
        t_reset_state();
        t_bias_hints();
        t_legacy(1'h1);
        t_enable();
        do_reset();
        check64({63'h0, hw_on}, 64'h0, "enable");
        rd(2'h1, `ADDR_BIAS_HINT, 64'h0, 1'h0);
        t_legacy(1'h1);
        tally_and_finish();
    end

    // a hang costs far more than the roughly 90 cycles the run needs
    initial begin
        #(50 * 4000);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // tb_top
